// *** adc_ctrl_pkg.sv ***
// shared constants and types for the converter control block
package adc_ctrl_pkg;

  // ---------------------------------------------------------------
  // conversion timing, in converter clock half-cycles
  // ---------------------------------------------------------------
  // sample phases are 3.5 / 23.5 converter clocks, counted in halves
  localparam int unsigned SHORT_SAMPLE_HALVES = 7;
  localparam int unsigned LONG_SAMPLE_HALVES = 47;
  localparam logic [5:0] SHORT_SAMPLE_CNT = 6'(SHORT_SAMPLE_HALVES);
  localparam logic [5:0] LONG_SAMPLE_CNT = 6'(LONG_SAMPLE_HALVES);
  // one approximation step per converter clock tick
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [4:0] CHANNEL_OFF = 5'h1F;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, TRANSFER} conv_state_e;

  typedef struct packed {
    logic convIrqEnable;
    logic continuousConvSel;
    logic [4:0] channelSelect;
  } status_control_s;

  typedef struct packed {
    logic longSampleSel;
    logic tenBitMode;
    logic asyncClockEnable;
    logic externalConvertMode;
  } config_s;

endpackage : adc_ctrl_pkg

// *** adc_lowpower_interrupt_ctrl.sv ***
// control logic of a successive-approximation converter with low-power handling
// How it works
// - short sample phase lasts 3.5 converter clocks before approximation begins.
// - long sample setting stretches the sample phase to 23.5 converter clocks.
// - ten-bit mode gives 1024 codes; eight-bit mode spans the same range.
// - result is rounded to the chosen width, error within half a code.
// - interrupt request rises when the complete flag sets and enable is on.
// - complete flag sets at every unblocked conversion end regardless of enable.
// - in wait mode conversions continue and interrupt still raised.
// - after a single conversion the converter falls back to low power.
// - low-power idle happens whatever channel is selected.
// - stop without async clock aborts conversion and forces low power.
// - after such a stop, only a control register write restarts conversion.
// - results hold the last completed value, untouched by aborts.
// - with async clock enabled, stop mode does not disturb conversions.
// - async clock plus external mode lets a hardware trigger start in stop.
// - awaiting that trigger stays low power, converts once, then interrupts.
// - completion is the result transfer, which sets the complete flag.
// - continuous mode restarts after each completion, updating results.
// - interrupt clears on result low read or control register write.
module adc_lowpower_interrupt_ctrl (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // converter clock tick, one pulse per converter clock half-cycle
  input wire logic converterClockHalfTick,
  // software writes and reads
  input wire logic statusControlWrite,
  input wire adc_ctrl_pkg::status_control_s statusControlData,
  input wire adc_ctrl_pkg::config_s configBits,
  input wire logic resultHighRead,
  input wire logic resultLowRead,
  // cpu power modes and hardware trigger
  input wire logic cpuWaitMode,
  input wire logic cpuStopMode,
  input wire logic hwTrigger,
  // analog core: comparator answer for the current trial
  input wire logic compareHigh,
  // analog core controls
  output logic analogPowerOn,
  output logic sampleActive,
  output logic [10:0] trialCode,
  output logic [4:0] channelSelect,
  // status and results
  output logic convCompleteFlag,
  output logic convIrq,
  output logic [1:0] resultHighReg,
  output logic [7:0] resultLowReg,
  output logic busy
);

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  adc_ctrl_pkg::conv_state_e state_q;
  adc_ctrl_pkg::status_control_s ctrl_q;
  logic [5:0] sampleCnt_q;
  logic [3:0] bitIdx_q;
  logic [10:0] sar_q;
  logic [9:0] result_q;
  logic flag_q;
  logic irq_q;
  logic stopHalted_q;
  logic highReadPending_q;
  logic tick;
  logic channelOn;
  logic stopAbort;
  logic trigEdge;
  logic trig_q;
  logic swStart;
  logic [3:0] nBits;
  logic [5:0] sampleLen;
  logic [10:0] rounded;
  logic transferBlocked;
  logic doneEvent;
  logic [9:0] result10;
  logic [7:0] result8;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign tick = clkEn && converterClockHalfTick;
  assign channelOn = ctrl_q.channelSelect != adc_ctrl_pkg::CHANNEL_OFF;
  assign stopAbort = cpuStopMode && !configBits.asyncClockEnable;
  // a held trigger starts one conversion only, so waiting in stop stays quiet
  assign trigEdge = hwTrigger && !trig_q;
  assign swStart = statusControlWrite
                   && (statusControlData.channelSelect != adc_ctrl_pkg::CHANNEL_OFF);
  assign nBits = configBits.tenBitMode ? adc_ctrl_pkg::BITS_10 : adc_ctrl_pkg::BITS_8;
  assign sampleLen = configBits.longSampleSel ? adc_ctrl_pkg::LONG_SAMPLE_CNT
                                              : adc_ctrl_pkg::SHORT_SAMPLE_CNT;
  // round by adding half a code at the lsb below the result
  assign rounded = configBits.tenBitMode ? sar_q + 11'h001
                                         : sar_q + 11'h004;
  // saturate where the rounding carry drops off the top bit
  assign result10 = (rounded[10:1] == 10'h000 && sar_q[10]) ? 10'h3FF : rounded[10:1];
  assign result8 = (rounded[10:3] == 8'h00 && sar_q[10]) ? 8'hFF : rounded[10:3];
  // a half-read ten-bit result may not be overwritten
  assign transferBlocked = highReadPending_q && configBits.tenBitMode;
  // a blocked transfer drops its result and leaves the flag alone
  assign doneEvent = clkEn && state_q == adc_ctrl_pkg::TRANSFER && !transferBlocked;

  // ---------------------------------------------------------------
  // control register and trigger history
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
      trig_q <= 1'b0;
    end
    else if (clkEn)
    begin
      trig_q <= hwTrigger;
      if (statusControlWrite)
        ctrl_q <= statusControlData;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stopHalted_q <= 1'b0;
    else if (clkEn)
    begin
      if (statusControlWrite)
        stopHalted_q <= 1'b0;
      else if (stopAbort)
        stopHalted_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= adc_ctrl_pkg::IDLE;
      sampleCnt_q <= '0;
      bitIdx_q <= '0;
      sar_q <= '0;
    end
    else if (clkEn)
    begin
      if (stopAbort)
        state_q <= adc_ctrl_pkg::IDLE;
      else if (swStart)
      begin
        // a write aborts and restarts
        state_q <= adc_ctrl_pkg::SAMPLE;
        sampleCnt_q <= '0;
      end
      else if (statusControlWrite)
        state_q <= adc_ctrl_pkg::IDLE;
      else
      begin
        case (state_q)
          adc_ctrl_pkg::IDLE:
          begin
            if (configBits.externalConvertMode && trigEdge && channelOn && !stopHalted_q)
            begin
              state_q <= adc_ctrl_pkg::SAMPLE;
              sampleCnt_q <= '0;
            end
          end
          adc_ctrl_pkg::SAMPLE:
          begin
            if (tick)
            begin
              if (sampleCnt_q == sampleLen - 6'h01)
              begin
                state_q <= adc_ctrl_pkg::CONVERT;
                bitIdx_q <= '0;
                sar_q <= 11'h400;
              end
              else
                sampleCnt_q <= sampleCnt_q + 6'h01;
            end
          end
          adc_ctrl_pkg::CONVERT:
          begin
            // one trial per bit, plus a rounding guard bit
            if (tick)
            begin
              if (!compareHigh)
                sar_q[10 - bitIdx_q] <= 1'b0;
              if (bitIdx_q == nBits)
                state_q <= adc_ctrl_pkg::TRANSFER;
              else
              begin
                sar_q[9 - bitIdx_q] <= 1'b1;
                bitIdx_q <= bitIdx_q + 4'h1;
              end
            end
          end
          adc_ctrl_pkg::TRANSFER:
          begin
            // continuous restart; blocked transfers also retry
            if (ctrl_q.continuousConvSel && channelOn || transferBlocked)
            begin
              state_q <= adc_ctrl_pkg::SAMPLE;
              sampleCnt_q <= '0;
            end
            else
              // single conversion returns to low power
              state_q <= adc_ctrl_pkg::IDLE;
          end
          default:
            state_q <= adc_ctrl_pkg::IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // results
  // ---------------------------------------------------------------
  // results only change on completion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      result_q <= adc_ctrl_pkg::RESULT_RESET;
    else if (doneEvent)
    begin
      // transfer into result registers, saturating at full scale
      if (configBits.tenBitMode)
        result_q <= result10;
      else
        result_q <= {2'b00, result8};
    end
  end

  // ---------------------------------------------------------------
  // read order tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      highReadPending_q <= 1'b0;
    else if (clkEn)
    begin
      if (resultLowRead || statusControlWrite)
        highReadPending_q <= 1'b0;
      else if (resultHighRead)
        highReadPending_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // flag and interrupt
  // ---------------------------------------------------------------
  // flag sets at every completion; set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (doneEvent)
      flag_q <= 1'b1;
    else if (clkEn && (resultLowRead || statusControlWrite))
      flag_q <= 1'b0;
  end

  // irq follows completion when enabled, also in wait or stop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else if (doneEvent && ctrl_q.convIrqEnable)
      irq_q <= 1'b1;
    // cleared by low read or control write
    else if (clkEn && (resultLowRead || statusControlWrite))
      irq_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // power tracks activity only, not the channel code
  // waiting for a trigger keeps the core powered down
  assign analogPowerOn = state_q != adc_ctrl_pkg::IDLE;
  assign sampleActive = state_q == adc_ctrl_pkg::SAMPLE;
  assign busy = analogPowerOn;
  assign trialCode = sar_q;
  assign channelSelect = ctrl_q.channelSelect;
  assign convCompleteFlag = flag_q;
  // wait and async stop do not gate the request
  assign convIrq = irq_q;
  assign resultHighReg = result_q[9:8];
  assign resultLowReg = result_q[7:0];

endmodule : adc_lowpower_interrupt_ctrl

// *** adc_lowpower_interrupt_ctrl_props.sv ***
// assertions on the converter control block ports
module adc_lowpower_interrupt_ctrl_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software and power mode
  input wire logic statusControlWrite,
  input wire adc_ctrl_pkg::status_control_s statusControlData,
  input wire adc_ctrl_pkg::config_s configBits,
  input wire logic resultLowRead,
  input wire logic cpuStopMode,
  // status
  input wire logic analogPowerOn,
  input wire logic sampleActive,
  input wire logic busy,
  input wire logic convCompleteFlag,
  input wire logic convIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irqEn_q;
  logic contMode_q;
  logic [5:0] sampleLen_q;
  // software settings as last written
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqEn_q <= 1'b0;
      contMode_q <= 1'b0;
    end
    else if (statusControlWrite)
    begin
      irqEn_q <= statusControlData.convIrqEnable;
      contMode_q <= statusControlData.continuousConvSel;
    end
  end
  // counts clocks, so valid only while the half tick runs every clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sampleLen_q <= 6'h00;
    else
      sampleLen_q <= sampleActive ? sampleLen_q + 6'h01 : 6'h00;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_irq_at_done: assert property ($rose(convCompleteFlag) |-> convIrq == irqEn_q)
    else $error("irq disagrees with enable");
  chk_irq_needs_flag: assert property (convIrq |-> convCompleteFlag)
    else $error("irq without flag");
  chk_read_clears: assert property ((resultLowRead || statusControlWrite) && !busy
    |=> !convIrq && !convCompleteFlag) else $error("flag not cleared");
  chk_stop_aborts: assert property (cpuStopMode && !configBits.asyncClockEnable
    && !statusControlWrite |=> !busy && !analogPowerOn) else $error("stop did not abort");
  chk_idle_unpowered: assert property ($rose(convCompleteFlag) && !contMode_q |-> !busy)
    else $error("single conversion left powered");
  chk_sample_powered: assert property (sampleActive |-> busy && analogPowerOn)
    else $error("sampling unpowered");
  chk_short_sample: assert property ($fell(sampleActive) && busy
    && !configBits.longSampleSel |-> sampleLen_q == 6'h07) else $error("short sample length");
  chk_long_sample: assert property ($fell(sampleActive) && busy
    && configBits.longSampleSel |-> sampleLen_q == 6'h2F) else $error("long sample length");
  cov_irq: cover property ($rose(convIrq));
  cov_stop_abort: cover property (cpuStopMode && $fell(busy));
  cov_long: cover property ($fell(sampleActive) && configBits.longSampleSel);
endmodule : adc_lowpower_interrupt_ctrl_props

bind adc_lowpower_interrupt_ctrl adc_lowpower_interrupt_ctrl_props i_adc_lowpower_interrupt_ctrl_props (
  .clk, .rst, .statusControlWrite, .statusControlData, .configBits, .resultLowRead,
  .cpuStopMode, .analogPowerOn, .sampleActive, .busy, .convCompleteFlag, .convIrq);

// *** adc_lowpower_interrupt_ctrl_test.sv ***
// self-checking bench of the converter control block
module adc_lowpower_interrupt_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, statusControlWrite = 1'b0, resultLowRead = 1'b0;
  logic cpuWaitMode = 1'b0, cpuStopMode = 1'b0, hwTrigger = 1'b0;
  logic compareHigh, analogPowerOn, sampleActive, busy, convCompleteFlag, convIrq;
  logic [6:0] sc = 7'h00;
  logic [3:0] cfg = 4'h4;
  logic [10:0] level = 11'h000;
  logic [10:0] trialCode;
  logic [9:0] prev = 10'h000;
  logic [1:0] resultHighReg;
  logic [7:0] resultLowReg;
  logic [10:0] lv [5] = '{11'h000, 11'h001, 11'h2AB, 11'h7FE, 11'h7FF};
  int numErrors = 0, numChecks = 0, cycles = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (++cycles == 5000) endOfTest(1'b1);
  adc_lowpower_interrupt_ctrl i_adc_lowpower_interrupt_ctrl (.clk, .rst, .clkEn(1'b1),
    .converterClockHalfTick(1'b1), .statusControlWrite, .statusControlData(sc),
    .configBits(cfg), .resultHighRead(1'b0), .resultLowRead, .cpuWaitMode, .cpuStopMode,
    .hwTrigger, .compareHigh, .analogPowerOn, .sampleActive, .trialCode, .channelSelect(),
    .convCompleteFlag, .convIrq, .resultHighReg, .resultLowReg, .busy);
  analog_input_model i_analog_input_model (.trialCode, .inputLevel(level), .compareHigh);
  task check(input logic ok);
    numChecks++;
    numErrors += int'(ok !== 1'b1);
    if (ok !== 1'b1)
      $display("FAIL %0t value differs", $time);
  endtask : check
  task endOfTest(input bit hung);
    numErrors += int'(hung);
    $display("errors %0d checks %0d", numErrors, numChecks);
    if (numErrors == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : endOfTest
  function automatic logic [9:0] rnd(input logic [10:0] v);
    return (v == 11'h7FF) ? 10'h3FF : 10'((12'(v) + 12'h001) >> 1);
  endfunction : rnd
  function automatic logic [7:0] rnd8(input logic [10:0] v);
    return (v >= 11'h7FC) ? 8'hFF : 8'((12'(v) + 12'h004) >> 3);
  endfunction : rnd8
  task op(input logic w, r, input logic [6:0] d);
    @(negedge clk);
    statusControlWrite = w;
    resultLowRead = r;
    sc = d;
    @(negedge clk);
    statusControlWrite = 1'b0;
    resultLowRead = 1'b0;
  endtask : op
  task waitFlag(input logic [10:0] v);
    int n;
    for (n = 0; convCompleteFlag !== 1'b1 && n < 200; n++) @(negedge clk);
    check(n < 200);
    prev = cfg[2] ? rnd(v) : {2'b00, rnd8(v)};
    check({resultHighReg, resultLowReg} === prev);
  endtask : waitFlag
  task tSingle(input logic [10:0] v, input logic ien);
    level = v;
    op(1'b1, 1'b0, {ien, 6'h03});
    waitFlag(v);
    check(convIrq === ien);
    op(1'b0, 1'b1, sc);
    check(convIrq === 1'b0 && convCompleteFlag === 1'b0);
    check(busy === 1'b0 && analogPowerOn === 1'b0);
  endtask : tSingle
  task tCont;
    level = 11'h0FF;
    op(1'b1, 1'b0, 7'h22);
    waitFlag(11'h0FF);
    op(1'b0, 1'b1, sc);
    level = 11'h300;
    waitFlag(11'h300);
    // continuous mode cleared before going quiet
    op(1'b1, 1'b0, 7'h1F);
    check(busy === 1'b0 && analogPowerOn === 1'b0);
  endtask : tCont
  task tStopAbort;
    level = 11'h0A0;
    cfg = 4'h5;
    op(1'b1, 1'b0, 7'h64);
    repeat (3) @(negedge clk);
    cpuStopMode = 1'b1;
    repeat (2) @(negedge clk);
    check(busy === 1'b0 && analogPowerOn === 1'b0);
    check({resultHighReg, resultLowReg} === prev);
    cpuStopMode = 1'b0;
    // neither continuous mode nor a trigger may revive it
    hwTrigger = 1'b1;
    repeat (60) @(negedge clk);
    check(busy === 1'b0 && convCompleteFlag === 1'b0);
    hwTrigger = 1'b0;
    tSingle(11'h0A0, 1'b1);
  endtask : tStopAbort
  task tTrigger;
    cfg = 4'h7;
    cpuStopMode = 1'b1;
    tSingle(11'h155, 1'b1);
    level = 11'h2AA;
    repeat (5) @(negedge clk);
    check(analogPowerOn === 1'b0);
    hwTrigger = 1'b1;
    waitFlag(11'h2AA);
    check(convIrq === 1'b1);
    check(busy === 1'b0);
    cpuStopMode = 1'b0;
    hwTrigger = 1'b0;
  endtask : tTrigger
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (lv[i]) tSingle(lv[i], 1'b1);
    cfg = 4'hC;
    tSingle(11'h123, 1'b0);
    cfg = 4'h0;
    tSingle(11'h0F0, 1'b1);
    cfg = 4'h4;
    cpuWaitMode = 1'b1;
    tSingle(11'h3C1, 1'b1);
    cpuWaitMode = 1'b0;
    tCont;
    tStopAbort;
    tTrigger;
    endOfTest(1'b0);
  end
endmodule : adc_lowpower_interrupt_ctrl_test

// *** analog_input_model.sv ***
// comparator model of the analog input seen by the converter
module analog_input_model (
  // trial code and input level, both in half codes
  input wire logic [10:0] trialCode,
  input wire logic [10:0] inputLevel,
  // comparator answer
  output logic compareHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  assign compareHigh = inputLevel >= trialCode;
endmodule : analog_input_model
